//--- pkg/sdc_pkg.sv
/*
  sdc_pkg: constants and state layout for the safe digital-input channel
  diagnosis block. Assumes a 25 MHz APB clock and eight input channels.
*/
package sdc_pkg;
  // ==========================================================
  // geometry and timing
  localparam int          NCH        = 8;
  localparam int          CLK_MHZ    = 25;       // pclk rate
  localparam int          CHK_US     = 1000;     // periodic check interval
  localparam int          CHK_CYC    = CHK_US * CLK_MHZ;
  localparam int          CNT_W      = 16;
  // ==========================================================
  // register byte offsets
  localparam logic [11:0] A_ENABLE   = 12'h000;  // channel enable
  localparam logic [11:0] A_MODE     = 12'h004;  // 1 = preset, 0 = hold last
  localparam logic [11:0] A_SAFEVAL  = 12'h008;  // preset safe values
  localparam logic [11:0] A_STATUS   = 12'h00c;  // image, faults
  localparam logic [11:0] A_ISTAT    = 12'h010;  // sticky events, read clears
  localparam logic [11:0] A_IMASK    = 12'h014;  // event mask
  localparam logic [11:0] A_LIVE     = 12'h018;  // live values
  localparam logic [6:0]  A_REC_PAGE = 7'h01;    // records at 0x020..0x03c
  // ==========================================================
  // reset values
  localparam logic [7:0]  RST_ENABLE = 8'hff;
  localparam logic [7:0]  RST_MODE   = 8'h00;
  localparam logic [7:0]  RST_SAFE   = 8'h00;
  localparam logic [15:0] RST_IMASK  = 16'h0000;
  // ==========================================================
  // diagnosis record fields
  localparam logic [7:0]  REC_HEAD   = 8'h80;
  localparam logic [1:0]  REC_IO_IN  = 2'h1;
  localparam logic [2:0]  REC_DT_BIT = 3'h1;
  localparam logic [4:0]  REC_FT_OK  = 5'h00;
  localparam logic [4:0]  REC_FT_ACQ = 5'h12;
  // ==========================================================
  // whole block state
  typedef struct packed {
    logic [7:0]       en;      // channel enable
    logic [7:0]       mode;    // substitution mode per channel
    logic [7:0]       sval;    // preset safe values
    logic [15:0]      msk;     // interrupt mask
    logic [15:0]      ist;     // [7:0] fault raised, [15:8] recovered
    logic [7:0]       acq;     // latched acquisition faults
    logic [7:0]       flt;     // channel in fault last cycle
    logic [7:0]       val;     // delivered channel values
    logic [7:0]       qual;    // quality bits
    logic [7:0]       live;    // live values
    logic [7:0]       safe;    // safe-side drive
    logic             ack;     // auto acknowledge pulse
    logic [CNT_W-1:0] cnt;     // check interval counter
    logic             chk;     // check strobe
    logic             pready;
    logic             pslverr;
    logic [31:0]      prdata;
    logic             irq;
  } sdc_state_t;
endpackage

//--- rtl/sdc_diag.sv
/*
  sdc_diag: channel diagnosis and safety value substitution for an
  eight-channel safety digital input, with an APB register slave.
  Assumes acquisition, module and communication fault flags arrive
  synchronous to pclk from the surrounding module logic.
*/
`timescale 1ns/1ns
module sdc_diag
  import sdc_pkg::*;
#(
  parameter int CHECK_CYCLES = sdc_pkg::CHK_CYC  // shorten in simulation
)(
  // clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output wire logic [31:0] prdata,
  output wire logic        pready,
  output wire logic        pslverr,
  // field side
  input  wire logic [7:0]  raw_in,        // acquired channel inputs
  input  wire logic [7:0]  acq_fault_in,  // acquisition check result
  input  wire logic [5:0]  module_fault,  // pwr, cpu, self, chan, adc, mon
  input  wire logic [2:0]  comm_fault,    // link, switch-down, no supply
  // channel image and status
  output wire logic [15:0] input_image,
  output wire logic [7:0]  live_channel_value,
  output wire logic [7:0]  safe_side,
  output wire logic        check_strobe,
  output wire logic        fault_ack,
  output wire logic        irq
);
  import sdc_pkg::*;

  // ==========================================================
  // state
  sdc_state_t st_r;     // registered state
  sdc_state_t st_nxt;   // next state
  logic       mod_fail; // any module failure
  logic       com_fail; // any communication failure
  logic [7:0] flt_now;  // per-channel fault this cycle
  logic [7:0] hold_m;   // channels holding last value
  logic [7:0] pre_m;    // channels taking preset value
  logic       acc;      // apb access completes this edge
  logic       rec_sel;  // address hits the record page

  // fault classification, shared by comb logic and checks
  always_comb
  begin
    mod_fail = |module_fault;
    com_fail = |comm_fault;
    // a disabled channel never faults, so never substitutes
    flt_now  = st_r.en & (st_r.acq | {NCH{mod_fail | com_fail}});
    hold_m   = flt_now & ~st_r.mode;
    pre_m    = flt_now & st_r.mode;
    acc      = psel & penable & st_r.pready;
    rec_sel  = (paddr[11:5] == A_REC_PAGE);
  end

  // ==========================================================
  // record builder: three bytes per channel, header first
  function automatic logic [23:0] rec(input logic [2:0] ch,
                                      input logic       acqf);
    logic [4:0] ft;
    ft = acqf ? REC_FT_ACQ : REC_FT_OK;
    rec = {REC_HEAD, REC_IO_IN, 3'h0, ch, REC_DT_BIT, ft};
  endfunction

  // ==========================================================
  // next-state logic
  always_comb
  begin
    st_nxt = st_r;
    // check interval: fires right out of reset, then every period
    st_nxt.chk = (st_r.cnt == '0);
    if (st_r.cnt >= CNT_W'(CHECK_CYCLES - 1))
    begin
      st_nxt.cnt = '0;
    end
    else
    begin
      st_nxt.cnt = st_r.cnt + CNT_W'(1);
    end
    // acquisition fault flags are only refreshed on the check strobe
    if (st_r.chk)
    begin
      st_nxt.acq = acq_fault_in;
    end
    // substitution; healthy channels follow the input again
    st_nxt.val  = (raw_in & ~flt_now)
                | (st_r.val & hold_m)
                | (st_r.sval & pre_m);
    st_nxt.qual = flt_now;
    st_nxt.safe = flt_now;
    st_nxt.live = raw_in;
    st_nxt.flt  = flt_now;
    // clearing of the last fault acknowledges without operator
    st_nxt.ack  = (|st_r.flt) & ~(|flt_now);
    // apb handshake: one wait state, answer registered
    st_nxt.pready  = psel & penable & ~st_r.pready;
    st_nxt.pslverr = 1'b0;
    if (~(psel & penable) | st_r.pready)
    begin
      st_nxt.prdata = '0;
    end
    else if (rec_sel)
    begin
      // a disabled channel reports an empty record
      if (st_r.en[paddr[4:2]] & ~pwrite)
      begin
        st_nxt.prdata = {8'h00, rec(paddr[4:2], st_r.acq[paddr[4:2]])};
      end
      else
      begin
        st_nxt.prdata = '0;
      end
    end
    else if (paddr == A_ENABLE)
    begin
      st_nxt.prdata = {24'h0, st_r.en};
    end
    else if (paddr == A_MODE)
    begin
      st_nxt.prdata = {24'h0, st_r.mode};
    end
    else if (paddr == A_SAFEVAL)
    begin
      st_nxt.prdata = {24'h0, st_r.sval};
    end
    else if (paddr == A_STATUS)
    begin
      st_nxt.prdata = {6'h0, com_fail, mod_fail, st_r.acq, st_r.qual,
                       st_r.val};
    end
    else if (paddr == A_ISTAT)
    begin
      st_nxt.prdata = {16'h0, st_r.ist};
    end
    else if (paddr == A_IMASK)
    begin
      st_nxt.prdata = {16'h0, st_r.msk};
    end
    else if (paddr == A_LIVE)
    begin
      st_nxt.prdata = {24'h0, st_r.live};
    end
    else
    begin
      // unmapped: error, read data zero
      st_nxt.prdata  = '0;
      st_nxt.pslverr = 1'b1;
    end
    // writes land on the completing edge only
    if (acc & pwrite)
    begin
      if (paddr == A_ENABLE)
      begin
        st_nxt.en = pwdata[7:0];
      end
      else if (paddr == A_MODE)
      begin
        // mode only sticks for enabled channels
        st_nxt.mode = pwdata[7:0] & st_r.en;
      end
      else if (paddr == A_SAFEVAL)
      begin
        st_nxt.sval = pwdata[7:0];
      end
      else if (paddr == A_IMASK)
      begin
        st_nxt.msk = pwdata[15:0];
      end
    end
    // sticky events; a read clears only the bits that it returned, so an
    // event landing between the data snapshot and the completing edge is
    // not lost; an event on the clearing edge itself survives (set wins)
    if (acc & ~pwrite & (paddr == A_ISTAT))
    begin
      st_nxt.ist = st_r.ist & ~st_r.prdata[15:0];
    end
    st_nxt.ist = st_nxt.ist | {st_r.flt & ~flt_now,
                               flt_now & ~st_r.flt};
    st_nxt.irq = |(st_nxt.ist & st_nxt.msk);
  end

  // ==========================================================
  // state register
  // the reset branch loads constants only; all other fields clear to zero
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_r      <= '0;
      st_r.en   <= RST_ENABLE;
      st_r.mode <= RST_MODE;
      st_r.sval <= RST_SAFE;
      st_r.msk  <= RST_IMASK;
    end
    else
    begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from the state register
  // no logic after the flops, so the far side never sees a decode glitch
  assign prdata             = st_r.prdata;
  assign pready             = st_r.pready;
  assign pslverr            = st_r.pslverr;
  assign input_image        = {st_r.qual, st_r.val};
  assign live_channel_value = st_r.live;
  assign safe_side          = st_r.safe;
  assign check_strobe       = st_r.chk;
  assign fault_ack          = st_r.ack;
  assign irq                = st_r.irq;

  // ==========================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  // record header is fixed for every enabled channel
  rec_head_a: assert property (
    (acc & ~pwrite & rec_sel & st_r.en[paddr[4:2]]) |->
      (prdata[23:16] == 8'h80))
    else $error("record header byte wrong");

  // second byte carries input type and channel index
  rec_chan_a: assert property (
    (acc & ~pwrite & rec_sel & st_r.en[paddr[4:2]]) |->
      (prdata[15:8] == (8'd64 + {5'd0, paddr[4:2]})))
    else $error("record channel byte wrong");

  // fault byte was built one edge before the completing edge
  rec_type_a: assert property (
    (acc & ~pwrite & rec_sel & st_r.en[paddr[4:2]]) |->
      (prdata[7:0] == ($past(st_r.acq[paddr[4:2]]) ? 8'd50 : 8'd32)))
    else $error("record fault byte wrong");

  // every faulty channel is flagged and forced safe next cycle
  quality_set_a: assert property (
    (flt_now != 8'h00) |=> ((st_r.qual & st_r.safe & $past(flt_now)) == $past(flt_now)))
    else $error("faulty channel lacks quality or safe side");

  // hold mode freezes the delivered bit
  hold_last_a: assert property (
    1'b1 |=> (((st_r.val ^ $past(st_r.val)) & $past(hold_m)) == 8'h00))
    else $error("held channel changed value");

  // preset mode delivers the configured safe bit
  preset_a: assert property (
    1'b1 |=> (((st_r.val ^ $past(st_r.sval)) & $past(pre_m)) == 8'h00))
    else $error("preset channel not at safe value");

  // live value is never substituted
  live_a: assert property (
    1'b1 |=> (live_channel_value == $past(raw_in)))
    else $error("live value does not track input");

  // strobe is a single pulse right after the counter wraps
  check_a: assert property (
    check_strobe |-> (st_r.cnt == CNT_W'(1)) ##1 !check_strobe)
    else $error("check strobe misplaced");

  // clearing of the last fault acknowledges at once
  auto_ack_a: assert property (
    $fell(|st_r.flt) |-> fault_ack)
    else $error("fault clear not acknowledged");

  // a disabled channel never shows a quality flag
  disabled_a: assert property (
    1'b1 |=> ((st_r.qual & ~$past(st_r.en)) == 8'h00))
    else $error("disabled channel flagged");

  // interrupt level follows unmasked sticky events
  irq_a: assert property (
    irq == |(st_r.ist & st_r.msk))
    else $error("interrupt level wrong");

  // a completed transfer answers for one cycle only
  apb_pulse_a: assert property (
    pready |=> !pready)
    else $error("pready longer than one cycle");

  // an answer always belongs to a request in its access phase
  apb_answer_a: assert property (
    pready |-> $past(psel & penable))
    else $error("pready without access phase");

  // an error answer carries no data
  slverr_zero_a: assert property (
    pslverr |-> (pready & (prdata == 32'h0)))
    else $error("error answer with data or without pready");

  // a raised fault event is latched even on a read-clear edge
  event_sticky_a: assert property (
    ((flt_now & ~st_r.flt) != 8'h00) |=>
      ((st_r.ist[7:0] & $past(flt_now & ~st_r.flt)) == $past(flt_now & ~st_r.flt)))
    else $error("fault event lost");

  // the acknowledge is a single pulse per clearing
  ack_pulse_a: assert property (
    fault_ack |=> !fault_ack)
    else $error("acknowledge longer than one cycle");

  // safe side and quality agree channel by channel
  safe_qual_a: assert property (
    safe_side == input_image[15:8])
    else $error("safe side and quality disagree");

  // ==========================================================
  // scenario coverage
  fault_cov:   cover property ($rose(|st_r.qual));
  recover_cov: cover property ($fell(|st_r.qual) ##1 fault_ack);
  preset_cov:  cover property ((pre_m != 8'h00) ##1 (st_r.val != raw_in));
  clear_cov:   cover property (acc & ~pwrite & (paddr == A_ISTAT) & irq);
  hold_cov:    cover property ((hold_m != 8'h00) ##1 (st_r.val != raw_in));

endmodule

//--- bench/sdc_master_model.sv
/*
  sdc_master_model: fieldbus master at the far side of the block.
  Assumes the bench drives cause_cmd right after a rising edge.
*/
`timescale 1ns/1ns
module sdc_master_model (
  // clock
  input  wire logic        pclk,
  // bench command, observed image
  input  wire logic [2:0]  cause_cmd,   // link, switch-down, no supply
  input  wire logic [15:0] input_image,
  input  wire logic [7:0]  live_value,
  // toward the block and user logic
  output logic      [2:0]  comm_fault,
  output logic      [7:0]  user_val
);
  // ==========================================
  // link side: causes follow the command one edge late
  always_ff @(posedge pclk)
    comm_fault <= cause_cmd;
  // user logic takes the live value of a bad channel
  assign user_val = (input_image[15:8] & live_value)
                  | (~input_image[15:8] & input_image[7:0]);
endmodule

//--- bench/tb_sdc_diag.sv
/*
  tb_sdc_diag: self-checking bench for sdc_diag.
  Assumes CHECK_CYCLES set to CHK_SIM; the apb master waits for pready.
*/
`timescale 1ns/1ns
module tb_sdc_diag;
  import sdc_pkg::*;
  localparam int CHK_SIM = 8;  // short check period for simulation
  // ==========================================
  // signals
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [7:0]  raw_in = 8'h00;
  logic [7:0]  acq_fault_in = 8'h00;
  logic [5:0]  module_fault = 6'h00;
  logic [2:0]  comm_fault;
  logic [2:0]  cause_cmd = 3'h0;
  logic [15:0] input_image;
  logic [7:0]  live;
  logic [7:0]  safe_side;
  logic        check_strobe;
  logic        fault_ack;
  logic        irq;
  logic [7:0]  user_val;
  int          fails = 0;
  int          n_tests = 0;
  int          cycles = 0;
  // clock, reset, hang guard
  always #20 pclk = ~pclk;
  always @(posedge pclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      fails++;
      $display("[FAIL] %0t timeout", $time);
      wrap_up();
    end
  end
  sdc_diag #(.CHECK_CYCLES(CHK_SIM)) u_sdc_diag (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .raw_in(raw_in), .acq_fault_in(acq_fault_in),
    .module_fault(module_fault), .comm_fault(comm_fault), .input_image(input_image),
    .live_channel_value(live), .safe_side(safe_side), .check_strobe(check_strobe),
    .fault_ack(fault_ack), .irq(irq));
  sdc_master_model u_sdc_master_model (.pclk(pclk), .cause_cmd(cause_cmd),
    .input_image(input_image), .live_value(live), .comm_fault(comm_fault),
    .user_val(user_val));
  // ==========================================
  // shared tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  // one apb transfer, held until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d,
                     output logic [31:0] q, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // wait for the edge that samples pready high; only the bench timeout ends it
    do
    begin
      @(posedge pclk);
    end
    while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input logic eexp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(q, exp, "read data");
    chk({31'h0, e}, {31'h0, eexp}, "slave error");
  endtask
  task automatic settle(input int n);
    repeat (n) @(negedge pclk);
  endtask
  // ==========================================
  // scenarios
  task automatic t_reset();
    int n;
    // power-on check on the first edge after release, then once a period
    settle(2);
    chk(check_strobe, 1'b1, "power-on check");
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (check_strobe !== 1'b1 && n < 20);
    chk(n, CHK_SIM, "check period");
    rd(A_ENABLE, 32'hff, 1'b0);
    rd(A_MODE, 32'h0, 1'b0);
    rd(A_IMASK, 32'h0, 1'b0);
    rd(12'h01c, 32'h0, 1'b1);  // unmapped
    for (int c = 0; c < 8; c++)
      rd(12'h020 + 12'(4 * c), {16'h0080, 8'h40 + 8'(c), 8'h20}, 1'b0);
    $display("test reset done");
  endtask
  task automatic t_hold();
    wr(A_IMASK, 32'h0404);
    @(posedge pclk);
    raw_in <= 8'ha5;
    acq_fault_in <= 8'h04;
    settle(20);
    @(posedge pclk);
    raw_in <= 8'h5a;
    settle(2);
    chk(input_image, 16'h045e, "hold image");
    chk(safe_side, 8'h04, "safe side");
    chk(user_val, 8'h5a, "live value");
    chk(live, 8'h5a, "live value direct");
    chk(irq, 1'b1, "irq raised");
    rd(12'h028, 32'h00804232, 1'b0);
    rd(A_STATUS, 32'h0004045e, 1'b0);
    $display("test hold done");
  endtask
  task automatic t_recover();
    int n;
    rd(A_ISTAT, 32'h0004, 1'b0);
    @(posedge pclk);
    acq_fault_in <= 8'h00;
    n = 0;
    do
    begin
      @(negedge pclk);
      n++;
    end
    while (fault_ack !== 1'b1 && n < 30);
    chk(fault_ack, 1'b1, "auto ack");
    settle(1);
    chk(input_image, 16'h005a, "recovered image");
    rd(12'h028, 32'h00804220, 1'b0);
    rd(A_ISTAT, 32'h0400, 1'b0);
    settle(2);
    chk(irq, 1'b0, "irq cleared");
    $display("test recover done");
  endtask
  task automatic t_preset();
    wr(A_MODE, 32'hff);
    wr(A_SAFEVAL, 32'h0f);
    for (int i = 0; i < 9; i++)
    begin
      @(posedge pclk);
      if (i < 6)
        module_fault <= 6'(1 << i);
      else
        cause_cmd <= 3'(1 << (i - 6));
      settle(3);
      chk(input_image, 16'hff0f, "preset image");
      chk(safe_side, 8'hff, "all safe");
      @(posedge pclk);
      module_fault <= 6'h00;
      cause_cmd <= 3'h0;
      settle(3);
      chk(input_image, 16'h005a, "cause gone");
    end
    $display("test preset done");
  endtask
  task automatic t_disabled();
    wr(A_ENABLE, 32'hfe);
    @(posedge pclk);
    module_fault <= 6'h01;
    settle(3);
    chk(input_image, 16'hfe0e, "disabled channel");
    rd(12'h020, 32'h0, 1'b0);
    @(posedge pclk);
    module_fault <= 6'h00;
    $display("test disabled done");
  endtask
  // ==========================================
  // verdict
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_hold();
    t_recover();
    t_preset();
    t_disabled();
    wrap_up();
  end
endmodule
